/* File: core/bcfg_pkg.sv */
// constants for the bridge configuration id and command registers
package bcfg_pkg;
	localparam logic [7:0]  BCFG_OFF_ID       = 8'h00;
	localparam logic [7:0]  BCFG_OFF_CMD      = 8'h04;
	localparam int          BCFG_VID_LSB      = 0;
	localparam int          BCFG_DID_LSB      = 16;
	localparam int          BCFG_CMD_IO_EN    = 0;
	localparam int          BCFG_CMD_MEM_EN   = 1;
	localparam int          BCFG_CMD_MASTER   = 2;
	localparam int          BCFG_CMD_SPECIAL  = 3;
	localparam int          BCFG_CMD_MWI      = 4;
	localparam int          BCFG_CMD_SNOOP    = 5;
	localparam int          BCFG_CMD_PERR     = 6;
	localparam int          BCFG_CMD_WAIT     = 7;
	localparam int          BCFG_CMD_SERR     = 8;
	localparam int          BCFG_CMD_FBB      = 9;
	localparam int          BCFG_CMD_INT_DIS  = 10;
	localparam int          BCFG_STS_MDPE     = 24;
	localparam logic [15:0] BCFG_CMD_RW_MASK  = 16'h0567;
	localparam logic [15:0] BCFG_CMD_RST      = 16'h0000;
	localparam logic [9:0]  BCFG_PAL_A0       = 10'h3C6;
	localparam logic [9:0]  BCFG_PAL_A1       = 10'h3C8;
	localparam logic [9:0]  BCFG_PAL_A2       = 10'h3C9;
endpackage : bcfg_pkg

/* File: core/bcfg_regs.sv */
// configuration id and command register block of the bridge
`timescale 1ns/10ps

module bcfg_regs import bcfg_pkg::*; #(
	parameter logic [15:0] VENDOR_CODE = 16'hA5A5, // arbitrary value
	parameter logic [15:0] DEVICE_CODE = 16'h5A5A  // arbitrary value
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        transparent_mode,
	input  wire logic        reverse_mode,
	input  wire logic        cfg_rd,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata,
	output logic             cfg_ack,
	input  wire logic        pri_io_wr,
	input  wire logic [15:0] pri_io_addr,
	input  wire logic        parity_event,
	input  wire logic        error_event,
	input  wire logic        int_req,
	output logic             io_resp_en,
	output logic             mem_accept_en,
	output logic             master_en,
	output logic             palette_hit,
	output logic             error_msg_req,
	output logic             serr_assert,
	output logic             inta_assert,
	output logic             mdpe_status
);
	typedef struct packed {
		logic [15:0] cmd;
		logic        mdpe;
		logic [31:0] rdata;
		logic        ack;
		logic        io_en;
		logic        mem_en;
		logic        mst_en;
		logic        pal_hit;
		logic        err_msg;
		logic        serr;
		logic        inta;
	} bcfg_state_s;

	bcfg_state_s s_q;
	bcfg_state_s s_d;

	function automatic logic bcfg_is_palette(input logic [9:0] a);
		bcfg_is_palette = (a == BCFG_PAL_A0) || (a == BCFG_PAL_A1) ||
			(a == BCFG_PAL_A2);
	endfunction : bcfg_is_palette

	logic [15:0] wmask;
	logic [15:0] cmd_next;
	logic        hit_cmd;
	logic        hit_id;

	always_comb begin
		s_d = s_q;
		wmask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}} & BCFG_CMD_RW_MASK;
		hit_cmd = transparent_mode && (cfg_addr == BCFG_OFF_CMD);
		hit_id = transparent_mode && (cfg_addr == BCFG_OFF_ID);
		cmd_next = s_q.cmd;
		if (cfg_wr && hit_cmd) begin
			cmd_next = (s_q.cmd & ~wmask) | (cfg_wdata[15:0] & wmask);
		end
		if (!reverse_mode) begin
			cmd_next[BCFG_CMD_SNOOP] = 1'b0;
			cmd_next[BCFG_CMD_INT_DIS] = 1'b0;
		end
		s_d.cmd = cmd_next;
		// set wins over a same-cycle clear
		if (cfg_wr && hit_cmd && cfg_be[3] && cfg_wdata[BCFG_STS_MDPE]) begin
			s_d.mdpe = 1'b0;
		end
		if (parity_event && s_q.cmd[BCFG_CMD_PERR]) begin
			s_d.mdpe = 1'b1;
		end
		s_d.ack = cfg_rd || cfg_wr;
		s_d.rdata = 32'h0000_0000;
		if (cfg_rd && hit_id) begin
			s_d.rdata = {DEVICE_CODE, VENDOR_CODE};
		end else if (cfg_rd && hit_cmd) begin
			s_d.rdata = {7'h00, s_q.mdpe, 8'h00, s_q.cmd};
		end
		s_d.io_en = s_q.cmd[BCFG_CMD_IO_EN];
		s_d.mem_en = s_q.cmd[BCFG_CMD_MEM_EN];
		s_d.mst_en = s_q.cmd[BCFG_CMD_MASTER];
		s_d.pal_hit = reverse_mode && s_q.cmd[BCFG_CMD_SNOOP] && pri_io_wr &&
			bcfg_is_palette(pri_io_addr[9:0]);
		s_d.err_msg = !reverse_mode && s_q.cmd[BCFG_CMD_SERR] &&
			error_event;
		s_d.serr = reverse_mode && s_q.cmd[BCFG_CMD_SERR] && error_event;
		s_d.inta = int_req &&
			!(reverse_mode && s_q.cmd[BCFG_CMD_INT_DIS]);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cfg_rdata = s_q.rdata;
	assign cfg_ack = s_q.ack;
	assign io_resp_en = s_q.io_en;
	assign mem_accept_en = s_q.mem_en;
	assign master_en = s_q.mst_en;
	assign palette_hit = s_q.pal_hit;
	assign error_msg_req = s_q.err_msg;
	assign serr_assert = s_q.serr;
	assign inta_assert = s_q.inta;
	assign mdpe_status = s_q.mdpe;

	property p_id_read;
		@(posedge ref_clk) disable iff (rst)
		cfg_rd && transparent_mode && cfg_addr == BCFG_OFF_ID |=>
			cfg_rdata == {DEVICE_CODE, VENDOR_CODE};
	endproperty
	a_id_read: assert property (p_id_read) else $error("id word wrong");

	property p_ro_zero;
		@(posedge ref_clk) disable iff (rst)
		cfg_rd && transparent_mode && cfg_addr == BCFG_OFF_CMD |=>
			cfg_rdata[15:11] == 5'h00 && cfg_rdata[9] == 1'b0 &&
			cfg_rdata[7] == 1'b0 && cfg_rdata[4:3] == 2'b00;
	endproperty
	a_ro_zero: assert property (p_ro_zero) else $error("ro bits set");

	property p_io_en;
		@(posedge ref_clk) disable iff (rst)
		cfg_wr && transparent_mode && cfg_addr == BCFG_OFF_CMD && cfg_be[0]
			|=> ##1 io_resp_en == $past(cfg_wdata[0], 2);
	endproperty
	a_io_en: assert property (p_io_en) else $error("io enable wrong");

	property p_mem_en;
		@(posedge ref_clk) disable iff (rst)
		cfg_wr && transparent_mode && cfg_addr == BCFG_OFF_CMD && cfg_be[0]
			|=> ##1 mem_accept_en == $past(cfg_wdata[1], 2);
	endproperty
	a_mem_en: assert property (p_mem_en) else $error("mem enable wrong");

	property p_master;
		@(posedge ref_clk) disable iff (rst)
		cfg_wr && transparent_mode && cfg_addr == BCFG_OFF_CMD && cfg_be[0]
			|=> ##1 master_en == $past(cfg_wdata[2], 2);
	endproperty
	a_master: assert property (p_master) else $error("master wrong");

	property p_mdpe_gate;
		@(posedge ref_clk) disable iff (rst)
		$rose(mdpe_status) |-> $past(parity_event) &&
			$past(s_q.cmd[BCFG_CMD_PERR]);
	endproperty
	a_mdpe_gate: assert property (p_mdpe_gate) else $error("mdpe set");

	property p_mdpe_clr;
		@(posedge ref_clk) disable iff (rst)
		cfg_wr && transparent_mode && cfg_addr == BCFG_OFF_CMD && cfg_be[3]
			&& cfg_wdata[BCFG_STS_MDPE] && !parity_event |=> !mdpe_status;
	endproperty
	a_mdpe_clr: assert property (p_mdpe_clr) else $error("w1c fail");

	property p_inta_block;
		@(posedge ref_clk) disable iff (rst)
		reverse_mode && s_q.cmd[BCFG_CMD_INT_DIS] |=> !inta_assert;
	endproperty
	a_inta_block: assert property (p_inta_block) else $error("inta");

	property p_palette;
		@(posedge ref_clk) disable iff (rst)
		palette_hit |-> $past(reverse_mode) && $past(pri_io_wr) &&
			bcfg_is_palette($past(pri_io_addr[9:0]));
	endproperty
	a_palette: assert property (p_palette) else $error("palette");

	property p_serr;
		@(posedge ref_clk) disable iff (rst)
		serr_assert |-> $past(error_event) && $past(s_q.cmd[BCFG_CMD_SERR]);
	endproperty
	a_serr: assert property (p_serr) else $error("serr");

	sequence s_cfg_req;
		cfg_rd || cfg_wr;
	endsequence

	property p_ack;
		@(posedge ref_clk) disable iff (rst)
		s_cfg_req |=> cfg_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing");

	property p_ack_idle;
		@(posedge ref_clk) disable iff (rst)
		!cfg_rd && !cfg_wr |=> !cfg_ack;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("stray ack");

	sequence s_fwd_err;
		error_event && !reverse_mode && s_q.cmd[BCFG_CMD_SERR];
	endsequence

	property p_err_msg;
		@(posedge ref_clk) disable iff (rst)
		s_fwd_err |=> error_msg_req && !serr_assert;
	endproperty
	a_err_msg: assert property (p_err_msg) else $error("err msg");

	sequence s_pal_wr;
		reverse_mode && s_q.cmd[BCFG_CMD_SNOOP] && pri_io_wr &&
			bcfg_is_palette(pri_io_addr[9:0]);
	endsequence

	property p_pal_hit;
		@(posedge ref_clk) disable iff (rst)
		s_pal_wr |=> palette_hit;
	endproperty
	a_pal_hit: assert property (p_pal_hit) else $error("pal miss");

	// reverse-only bits must never survive a forward-mode cycle
	property p_fwd_bits;
		@(posedge ref_clk) disable iff (rst)
		!reverse_mode |=> !s_q.cmd[BCFG_CMD_SNOOP] &&
			!s_q.cmd[BCFG_CMD_INT_DIS];
	endproperty
	a_fwd_bits: assert property (p_fwd_bits) else $error("fwd bits");

	property p_mdpe_set;
		@(posedge ref_clk) disable iff (rst)
		parity_event && s_q.cmd[BCFG_CMD_PERR] |=> mdpe_status;
	endproperty
	a_mdpe_set: assert property (p_mdpe_set) else $error("mdpe lost");
endmodule : bcfg_regs

/* File: verif/bcfg_host.sv */
// upstream host model issuing configuration requests
`timescale 1ns/10ps
module bcfg_host (
	input  wire logic        ref_clk,
	output logic             cfg_rd,
	output logic             cfg_wr,
	output logic [7:0]       cfg_addr,
	output logic [3:0]       cfg_be,
	output logic [31:0]      cfg_wdata,
	input  wire logic [31:0] cfg_rdata,
	input  wire logic        cfg_ack
);
	initial begin
		{cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
	end

	// one request, held for its taking edge, answer one edge later
	task acc(input logic w, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		{cfg_wr, cfg_rd} <= {w, !w};
		{cfg_addr, cfg_be, cfg_wdata} <= {a, be, d};
		@(posedge ref_clk);
		{cfg_wr, cfg_rd} <= 2'h0;
		// released data shows a changed pattern, not the old value
		{cfg_addr, cfg_be, cfg_wdata} <= ~{a, be, d};
		@(posedge ref_clk);
		q = cfg_rdata;
	endtask : acc
endmodule : bcfg_host

/* File: verif/bridge_config_id_command_regs_tb.sv */
// self-checking bench for the configuration id and command registers
`timescale 1ns/10ps
module bridge_config_id_command_regs_tb;
	import bcfg_pkg::*;
	logic        ref_clk, rst, transparent_mode, reverse_mode, int_req;
	logic        pri_io_wr, parity_event, error_event, cfg_rd, cfg_wr;
	logic        cfg_ack, io_resp_en, mem_accept_en, master_en;
	logic        palette_hit, error_msg_req, serr_assert, inta_assert;
	logic        mdpe_status;
	logic [15:0] pri_io_addr;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, q;
	int          fail_count, samples_checked, cycles, ack_count;

	bcfg_regs dut (.*);
	bcfg_host host (.*);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk

	task summarize;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	task pulse(input logic [2:0] v, input logic [15:0] a);
		@(posedge ref_clk);
		{pri_io_wr, parity_event, error_event} <= v;
		pri_io_addr <= a;
		@(posedge ref_clk);
		{pri_io_wr, parity_event, error_event} <= 3'h0;
		@(posedge ref_clk);
	endtask : pulse

	// ceiling well above the 66 or so cycles the tests need
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		// every request must be answered by exactly one ack
		if (cfg_ack === 1'b1) begin
			ack_count <= ack_count + 1;
		end
		if (cycles == 2000) begin
			fail_count++;
			summarize();
		end
	end

	initial begin
		{rst, transparent_mode, reverse_mode, int_req} = 4'hC;
		{pri_io_wr, parity_event, error_event, pri_io_addr} = '0;
		{fail_count, samples_checked, cycles, ack_count} = '0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		host.acc(1'b0, BCFG_OFF_CMD, 4'hF, 32'h0, q);
		chk(q[15:0], BCFG_CMD_RST);
		chk({io_resp_en, mem_accept_en, master_en}, 3'h0);
		host.acc(1'b1, BCFG_OFF_ID, 4'hF, 32'hFFFF_FFFF, q);
		host.acc(1'b0, BCFG_OFF_ID, 4'hF, 32'h0, q);
		chk(q, 32'h5A5A_A5A5);
		$display("test identity done");
		int_req <= 1'b1;
		host.acc(1'b1, BCFG_OFF_CMD, 4'h3, 32'h0000_FFFF, q);
		host.acc(1'b0, BCFG_OFF_CMD, 4'hF, 32'h0, q);
		chk(q[15:0], 16'h0147);
		chk({io_resp_en, mem_accept_en, master_en, inta_assert}, 4'hF);
		pulse(3'h2, 16'h0);
		chk(mdpe_status, 1'b1);
		pulse(3'h1, 16'h0);
		chk({error_msg_req, serr_assert}, 2'h2);
		host.acc(1'b1, BCFG_OFF_CMD, 4'h8, 32'h0, q);
		host.acc(1'b0, BCFG_OFF_CMD, 4'hF, 32'h0, q);
		chk(q[24], 1'b1);
		host.acc(1'b1, BCFG_OFF_CMD, 4'h9, 32'h0100_0000, q);
		pulse(3'h2, 16'h0);
		host.acc(1'b0, BCFG_OFF_CMD, 4'hF, 32'h0, q);
		chk(q[24], 1'b0);
		$display("test forward command done");
		reverse_mode <= 1'b1;
		host.acc(1'b1, BCFG_OFF_CMD, 4'h3, 32'h0000_FFFF, q);
		host.acc(1'b0, BCFG_OFF_CMD, 4'hF, 32'h0, q);
		chk(q[15:0], 16'h0567);
		pulse(3'h4, 16'hF3C8);
		chk(palette_hit, 1'b1);
		pulse(3'h4, 16'h03C7);
		chk(palette_hit, 1'b0);
		pulse(3'h1, 16'h0);
		chk({error_msg_req, serr_assert, inta_assert}, 3'h2);
		$display("test reverse command done");
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		host.acc(1'b0, BCFG_OFF_CMD, 4'hF, 32'h0, q);
		chk(q[15:0], BCFG_CMD_RST);
		chk({io_resp_en, mem_accept_en, master_en, mdpe_status}, 4'h0);
		$display("test mid-run reset done");
		transparent_mode <= 1'b0;
		host.acc(1'b0, BCFG_OFF_ID, 4'hF, 32'h0, q);
		chk(q, 32'h0);
		@(posedge ref_clk);
		chk(ack_count, 32'd13);
		$display("test layout gate done");
		summarize();
	end
endmodule : bridge_config_id_command_regs_tb
